// *** serial_channel_pkg.sv ***
// Package for the serial channel transmit and error block.
// Assumes a single 25 MHz system clock and an AHB-Lite register bus.
package serial_channel_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;

  // Register byte offsets.
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DIV = 8'h0C;

  // Control field positions.
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_PE = 2;
  localparam int unsigned CTRL_ODD = 3;
  localparam int unsigned CTRL_DIR = 4;
  localparam int unsigned CTRL_EDGE = 5;
  localparam int unsigned CTRL_HSK = 6;
  localparam int unsigned CTRL_TB8 = 7;

  // Status field positions.
  localparam int unsigned ST_TXE = 0;
  localparam int unsigned ST_TXI = 1;
  localparam int unsigned ST_RXI = 2;
  localparam int unsigned ST_OVERRUN_ERROR_FLAG = 3;
  localparam int unsigned ST_PARITY_ERROR_FLAG = 4;
  localparam int unsigned ST_FRAMING_ERROR_FLAG = 5;
  localparam int unsigned ST_RB8 = 6;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h01;
  localparam logic [3:0] SAMPLES_PER_BIT = 4'hF;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SHIFT_BITS = 4'h8;

  typedef enum logic [1:0] {
    MODE_SHIFT = 2'b00,
    MODE_UART7 = 2'b01,
    MODE_UART8 = 2'b10,
    MODE_UART9 = 2'b11
  } mode_type;

  typedef struct packed {
    logic hsel;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
  } ahb_req_type;

  typedef struct packed {
    logic txd;
    logic sclk_out;
    logic sclk_oe_n;
    logic tx_irq;
    logic rx_irq;
  } pins_out_type;

  function automatic logic parity_of(input logic [8:0] d, input logic odd);
    parity_of = (^d) ^ odd;
  endfunction

endpackage

// *** serial_channel_tx_and_errors.sv ***
// Transmit path and receive error logic for one serial channel.
// Assumes pins arrive asynchronous to hclk and are synchronised here.
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ns

// Operation
// - Internal shift clock: data bit changes on its rising edge driven out.
// - External shift clock: shift on rising or falling edge by edge select.
// - UART: start at next bit tick after buffer write, strobing each shift.
// - A handshake enable bit turns clear-to-send gating on or off.
// - With handshake and pin high, finish frame, hold next, still interrupt.
// - Held frame starts at first falling bit-tick edge after pin falls.
// - Shift LSB first; buffer empty when the shifter loads, transmit interrupt when done.
// - Parity only when enabled and in 7 or 8 bit UART; sense selectable.
// - Transmit parity computed, sent as bit 7 or as ninth bit.
// - Receive parity flagged in the same cycle as transfer to second buffer; mismatch flags.
// - Overrun when new character completes while second buffer still unread.
// - Stop bit sampled thrice at centre; majority zero flags framing error.
// - Receive interrupt at ninth bit, parity bit or stop bit centre by mode.
// - Overrun with receive interrupt; parity at parity or stop centre.
// - UART transmit interrupt just before the stop bit goes out.
// - Shift mode interrupts right after final clock edge.
// - Internal clock: each write gives 8 bits and 8 clocks, then pending.
// - External clock: 8 bits shift only on partner edges, then pending.
// - Transmit counter divides the sample clock by sixteen.
// - On overrun discard new character; keep second buffer and ninth bit.
module serial_channel_tx_and_errors
  import serial_channel_pkg::*;
#(
  parameter int unsigned DIV_WIDTH = 8
) (
  // Clock, reset and enable.
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // AHB-Lite slave.
  input wire serial_channel_pkg::ahb_req_type ahb_req,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial pins.
  input wire logic receive_data_pin,
  input wire logic clear_to_send_pin,
  input wire logic serial_shift_clock_in,
  output serial_channel_pkg::pins_out_type pins
);
  import serial_channel_pkg::*;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SEND = 2'b01,
    TX_STOP = 2'b10
  } tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_DATA = 2'b01,
    RX_STOP = 2'b10
  } rx_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.
  logic [1:0] rxd_s_q, cts_s_q, sck_s_q;
  logic sck_d1_q, rxd_d1_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_s_q <= 2'b11;
      cts_s_q <= 2'b11;
      sck_s_q <= 2'b11;
      sck_d1_q <= 1'b1;
      rxd_d1_q <= 1'b1;
    end else if (clk_en) begin
      rxd_s_q <= {rxd_s_q[0], receive_data_pin};
      cts_s_q <= {cts_s_q[0], clear_to_send_pin};
      sck_s_q <= {sck_s_q[0], serial_shift_clock_in};
      sck_d1_q <= sck_s_q[1];
      rxd_d1_q <= rxd_s_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [7:0] ctrl_q, tx_buf_q, rx_buf_q;
  logic [DIV_WIDTH-1:0] div_q, div_cnt_q;
  logic txe_q, txi_q, rxi_q, overrun_error_flag_q, parity_error_flag_q, framing_error_flag_q, rb8_q, rx_full_q;
  logic wr_pend_q, rd_pend_q;
  logic [7:0] addr_q;
  logic tx_load, tx_done_irq, rx_done, rx_ovr, rx_parity_error_flag, rx_framing_error_flag;
  logic [7:0] rx_new;
  logic rx_new9;
  mode_type mode;
  logic par_on, shift_mode;

  assign mode = mode_type'(ctrl_q[CTRL_MODE_LSB +: 2]);
  assign shift_mode = (mode == MODE_SHIFT);
  assign par_on = ctrl_q[CTRL_PE] && (mode == MODE_UART7 || mode == MODE_UART8);

  wire take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1];
  wire do_wr = wr_pend_q;
  wire do_rd = rd_pend_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (clk_en) begin
      wr_pend_q <= take && ahb_req.hwrite;
      rd_pend_q <= take && !ahb_req.hwrite;
      if (take) begin
        addr_q <= ahb_req.haddr[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CTRL_RESET;
      div_q <= DIV_WIDTH'(DIV_RESET);
      tx_buf_q <= 8'h00;
    end else if (clk_en && do_wr) begin
      if (addr_q == OFS_CTRL) begin
        ctrl_q <= hwdata[7:0];
      end
      if (addr_q == OFS_DIV) begin
        div_q <= hwdata[DIV_WIDTH-1:0];
      end
      if (addr_q == OFS_DATA) begin
        tx_buf_q <= hwdata[7:0];
      end
    end
  end

  assign tx_load = do_wr && (addr_q == OFS_DATA);
  wire rd_data = do_rd && (addr_q == OFS_DATA);
  wire rd_stat = do_rd && (addr_q == OFS_STAT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !ahb_req.hwrite) begin
        unique case (ahb_req.haddr[7:0])
          OFS_DATA: hrdata <= {24'h00_0000, rx_buf_q};
          OFS_CTRL: hrdata <= {24'h00_0000, ctrl_q};
          OFS_STAT: hrdata <= {25'h000_0000, rb8_q, framing_error_flag_q, parity_error_flag_q, overrun_error_flag_q, rxi_q, txi_q,
                               txe_q};
          OFS_DIV: hrdata <= 32'(div_q);
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sample clock and transmit bit tick.
  logic samp_q;
  logic [3:0] tx_div_q;
  logic tick_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= '0;
      samp_q <= 1'b0;
    end else if (clk_en) begin
      samp_q <= 1'b0;
      if (div_cnt_q >= div_q - DIV_WIDTH'(1)) begin
        div_cnt_q <= '0;
        samp_q <= 1'b1;
      end else begin
        div_cnt_q <= div_cnt_q + DIV_WIDTH'(1);
      end
    end
  end

  // One tick per sixteen sample pulses; tick_q high for the upper half.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_div_q <= 4'h0;
      tick_q <= 1'b0;
    end else if (clk_en && samp_q) begin
      tx_div_q <= tx_div_q + 4'h1;
      tick_q <= tx_div_q[3] ^ (tx_div_q[2:0] == 3'h7);
    end
  end
  wire tick_rise = samp_q && (tx_div_q == SAMPLES_PER_BIT);
  wire tick_fall = samp_q && (tx_div_q == 4'h7);

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter.
  tx_state_type tx_st_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic tx_strobe_q, sclk_half_q;
  wire cts_ok = !ctrl_q[CTRL_HSK] || !cts_s_q[1];
  wire sck_edge = ctrl_q[CTRL_EDGE] ? (!sck_s_q[1] && sck_d1_q) : (sck_s_q[1] && !sck_d1_q);
  // A held frame keeps the falling tick for every bit, so all bits stay equally long.
  wire bit_tick = ctrl_q[CTRL_HSK] ? tick_fall : tick_rise;
  wire uart_start = !txe_q && cts_ok && bit_tick;
  wire [3:0] frame_len = (mode == MODE_UART7) ? (par_on ? 4'h8 : 4'h7) :
                         ((par_on || mode == MODE_UART9) ? 4'h9 : 4'h8);

  function automatic logic [9:0] frame_of(input logic [7:0] d, input mode_type m,
                                          input logic pe, input logic odd, input logic tb8);
    logic [9:0] f;
    f = {1'b1, tb8, d};
    if (m == MODE_UART7) begin
      f = {2'b11, pe ? parity_of({2'b00, d[6:0]}, odd) : d[7], d[6:0]};
    end else if (m == MODE_UART8 && pe) begin
      f = {1'b1, parity_of({1'b0, d}, odd), d};
    end
    frame_of = f;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_q <= TX_IDLE;
      tx_sh_q <= 10'h3FF;
      tx_cnt_q <= 4'h0;
      tx_strobe_q <= 1'b0;
      pins.sclk_out <= 1'b1;
      sclk_half_q <= 1'b0;
      pins.txd <= 1'b1;
    end else if (clk_en) begin
      tx_strobe_q <= 1'b0;
      unique case (tx_st_q)
        TX_IDLE: begin
          pins.sclk_out <= 1'b1;
          if (shift_mode && !txe_q) begin
            tx_cnt_q <= 4'h0;
            sclk_half_q <= 1'b0;
            tx_st_q <= TX_SEND;
            if (ctrl_q[CTRL_DIR]) begin
              tx_sh_q <= {2'b11, tx_buf_q};
            end else begin
              // The first bit stands before the first falling clock edge.
              pins.txd <= tx_buf_q[0];
              tx_sh_q <= {3'b111, tx_buf_q[7:1]};
            end
          end else if (!shift_mode && uart_start) begin
            tx_sh_q <= frame_of(tx_buf_q, mode, par_on, ctrl_q[CTRL_ODD],
                                ctrl_q[CTRL_TB8]);
            pins.txd <= 1'b0;
            tx_cnt_q <= 4'h0;
            tx_strobe_q <= 1'b1;
            tx_st_q <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (shift_mode && !ctrl_q[CTRL_DIR]) begin
            if (samp_q) begin
              sclk_half_q <= !sclk_half_q;
              if (sclk_half_q) begin
                pins.sclk_out <= 1'b1;
                pins.txd <= tx_sh_q[0];
                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                tx_cnt_q <= tx_cnt_q + 4'h1;
              end else if (tx_cnt_q == SHIFT_BITS) begin
                sclk_half_q <= 1'b0;
                tx_st_q <= TX_IDLE;
              end else begin
                pins.sclk_out <= 1'b0;
              end
            end
          end else if (shift_mode) begin
            if (sck_edge) begin
              pins.txd <= tx_sh_q[0];
              tx_sh_q <= {1'b1, tx_sh_q[9:1]};
              tx_cnt_q <= tx_cnt_q + 4'h1;
              if (tx_cnt_q == SHIFT_BITS - 4'h1) begin
                tx_st_q <= TX_IDLE;
              end
            end
          end else if (bit_tick) begin
            tx_strobe_q <= 1'b1;
            pins.txd <= tx_sh_q[0];
            tx_sh_q <= {1'b1, tx_sh_q[9:1]};
            tx_cnt_q <= tx_cnt_q + 4'h1;
            if (tx_cnt_q == frame_len) begin
              tx_st_q <= TX_STOP;
              pins.txd <= 1'b1;
            end
          end
        end
        TX_STOP: begin
          if (bit_tick) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  wire shift_done = (tx_st_q == TX_SEND) && shift_mode &&
                    ((!ctrl_q[CTRL_DIR] && samp_q && !sclk_half_q && tx_cnt_q == SHIFT_BITS) ||
                     (ctrl_q[CTRL_DIR] && sck_edge && tx_cnt_q == SHIFT_BITS - 4'h1));
  wire uart_pre_stop = (tx_st_q == TX_SEND) && !shift_mode && bit_tick &&
                       (tx_cnt_q == frame_len);
  assign tx_done_irq = shift_done || uart_pre_stop;
  wire tx_taken = (tx_st_q == TX_IDLE) && !txe_q && (shift_mode || uart_start);

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: bit sampling at 7th, 8th and 9th sample pulse.
  rx_state_type rx_st_q;
  logic [3:0] rx_ph_q, rx_bit_q;
  logic [2:0] rx_vote_q;
  logic [8:0] rx_sh_q;
  logic rx_par_q;
  wire vote = (rx_vote_q[0] & rx_vote_q[1]) | (rx_vote_q[1] & rx_vote_q[2]) |
              (rx_vote_q[0] & rx_vote_q[2]);
  wire [3:0] rx_len = frame_len;
  wire at_centre = samp_q && (rx_ph_q == SAMPLE_MID + 4'h1);
  wire early_irq = (mode == MODE_UART9) || (mode == MODE_UART8 && par_on);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_q <= RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_vote_q <= 3'h7;
      rx_sh_q <= 9'h000;
    end else if (clk_en && !shift_mode) begin
      if (samp_q) begin
        rx_ph_q <= rx_ph_q + 4'h1;
        if (rx_ph_q >= 4'h6 && rx_ph_q <= SAMPLE_MID) begin
          rx_vote_q <= {rx_vote_q[1:0], rxd_d1_q};
        end
      end
      unique case (rx_st_q)
        RX_IDLE: begin
          rx_ph_q <= 4'h0;
          rx_bit_q <= 4'h0;
          if (!rxd_d1_q) begin
            rx_st_q <= RX_DATA;
          end
        end
        RX_DATA: begin
          if (at_centre) begin
            if (rx_bit_q == 4'h0) begin
              rx_st_q <= vote ? RX_IDLE : RX_DATA;
            end else begin
              rx_sh_q <= {vote, rx_sh_q[8:1]};
            end
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == rx_len) begin
              rx_st_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (at_centre) begin
            rx_st_q <= RX_IDLE;
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  wire last_data = (rx_st_q == RX_DATA) && at_centre && rx_bit_q == rx_len;
  wire stop_ctr = (rx_st_q == RX_STOP) && at_centre;
  // In the stop bit the shifter already holds the whole character.
  wire [8:0] rx_cat = (rx_st_q == RX_STOP) ? rx_sh_q : {vote, rx_sh_q[8:1]};
  wire [8:0] rx_word = rx_cat >> (4'h9 - rx_len);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_par_q <= 1'b0;
    end else if (clk_en && last_data) begin
      rx_par_q <= (mode == MODE_UART7) ? (par_on && (parity_of({2'b00, rx_word[6:0]},
                  ctrl_q[CTRL_ODD]) != rx_word[7])) : (parity_of({1'b0, rx_word[7:0]},
                  ctrl_q[CTRL_ODD]) != rx_word[8]);
    end
  end
  assign rx_done = early_irq ? last_data : stop_ctr;
  assign rx_ovr = rx_done && rx_full_q;
  assign rx_parity_error_flag = par_on && (mode == MODE_UART8 ? last_data && (parity_of({1'b0,
                   rx_word[7:0]}, ctrl_q[CTRL_ODD]) != rx_word[8]) :
                   stop_ctr && rx_par_q);
  assign rx_framing_error_flag = stop_ctr && !vote;
  assign rx_new = (mode == MODE_UART7 && !par_on) ? {1'b0, rx_word[6:0]} : rx_word[7:0];
  assign rx_new9 = rx_word[8];

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer two and status flags; hardware set wins over read clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buf_q <= 8'h00;
      rb8_q <= 1'b0;
      rx_full_q <= 1'b0;
      rxi_q <= 1'b0;
    end else if (clk_en) begin
      if (rx_done && !rx_full_q) begin
        rx_buf_q <= rx_new;
        rb8_q <= early_irq ? rx_new9 : rb8_q;
        rx_full_q <= 1'b1;
        rxi_q <= 1'b1;
      end else if (rd_data) begin
        rx_full_q <= 1'b0;
        rxi_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_error_flag_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
    end else if (clk_en) begin
      overrun_error_flag_q <= rx_ovr || (overrun_error_flag_q && !rd_stat);
      parity_error_flag_q <= rx_parity_error_flag || (parity_error_flag_q && !rd_stat);
      framing_error_flag_q <= rx_framing_error_flag || (framing_error_flag_q && !rd_stat);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txe_q <= 1'b1;
      txi_q <= 1'b0;
    end else if (clk_en) begin
      if (tx_load) begin
        txe_q <= 1'b0;
      end else if (tx_taken) begin
        txe_q <= 1'b1;
      end
      txi_q <= tx_done_irq || (txi_q && !tx_load);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins.sclk_oe_n <= 1'b1;
      pins.tx_irq <= 1'b0;
      pins.rx_irq <= 1'b0;
    end else if (clk_en) begin
      pins.sclk_oe_n <= !(shift_mode && !ctrl_q[CTRL_DIR]);
      pins.tx_irq <= tx_done_irq;
      pins.rx_irq <= rx_done && !rx_full_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  property p_lsb_first;
    @(posedge hclk) disable iff (!hresetn)
      tx_taken && !shift_mode |=> tx_sh_q[0] == $past(tx_buf_q[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("lsb not first");

  property p_cts_hold;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_q[CTRL_HSK] && cts_s_q[1] && tx_st_q == TX_IDLE |=> tx_st_q == TX_IDLE;
  endproperty
  a_cts_hold: assert property (p_cts_hold) else $error("frame began under cts");

  property p_ovr_keep;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && rx_ovr && !rd_data |=> $stable(rx_buf_q) && overrun_error_flag_q;
  endproperty
  a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost buffer");

  property p_framing_error_flag;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && rx_framing_error_flag |=> framing_error_flag_q;
  endproperty
  a_framing_error_flag: assert property (p_framing_error_flag) else $error("framing flag missed");

  property p_tick16;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && tick_rise |=> tx_div_q == 4'h0;
  endproperty
  a_tick16: assert property (p_tick16) else $error("tick divide wrong");

  property p_txirq;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && uart_pre_stop |=> pins.tx_irq && pins.txd;
  endproperty
  a_txirq: assert property (p_txirq) else $error("tx irq not before stop");

  property p_start;
    @(posedge hclk) disable iff (!hresetn)
      clk_en && uart_start && tx_st_q == TX_IDLE && !shift_mode |=> !pins.txd ##0 tx_strobe_q;
  endproperty
  a_start: assert property (p_start) else $error("start bit missing");

  property p_parity_error_flag_off;
    @(posedge hclk) disable iff (!hresetn)
      !par_on |-> !rx_parity_error_flag;
  endproperty
  a_parity_error_flag_off: assert property (p_parity_error_flag_off) else $error("parity without enable");

endmodule

// *** remote_peer.sv ***
// Remote partner: UART line, clear-to-send line and external shift register.
// Assumes a divider of one, so one bit lasts 16 clock cycles.
`timescale 1ns/1ns
module remote_peer (
  // Clock.
  input wire logic hclk,
  // Lines from the block.
  input wire logic txd,
  input wire logic sclk_out,
  // Lines to the block.
  output logic rxd,
  output logic cts,
  output logic sclk_in,
  output logic hung
);
  initial begin
    rxd = 1'b1;
    cts = 1'b0;
    sclk_in = 1'b1;
    hung = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask
  // A receiver that wants a pause raises the clear-to-send line.
  task automatic hold(input logic v);
    tick(1);
    cts <= v;
  endtask
  task automatic send(input int nb, input logic [8:0] d, input logic stp);
    for (int i = -1; i <= nb; i++) begin
      rxd <= (i < 0) ? 1'b0 : (i == nb) ? stp : d[i];
      tick(16);
    end
    rxd <= 1'b1;
    tick(16);
  endtask
  // Samples each bit at its centre, stop bit last.
  task automatic recv(input int nb, output logic [9:0] q);
    int n;
    q = '0;
    n = 0;
    while (txd !== 1'b0 && n < 400) begin
      @(negedge hclk);
      n++;
    end
    if (n == 400) hung <= 1'b1;
    repeat (8) @(negedge hclk);
    for (int i = 0; i <= nb; i++) begin
      repeat (16) @(negedge hclk);
      q[i] = txd;
    end
  endtask
  // Takes a bit at each fall of the block's shift clock.
  task automatic shift_int(output logic [7:0] q, output int falls);
    logic p;
    falls = 0;
    p = sclk_out;
    repeat (200) begin
      @(negedge hclk);
      if (p === 1'b1 && sclk_out === 1'b0) begin
        q = {txd, q[7:1]};
        falls++;
      end
      p = sclk_out;
    end
  endtask
  // Gives eight active edges and takes a bit after each; clock then stands.
  task automatic shift_ext(input logic fall, output logic [7:0] q);
    for (int i = 0; i < 8; i++) begin
      tick(1);
      sclk_in <= fall;
      tick(8);
      sclk_in <= ~fall;
      tick(8);
      q = {txd, q[7:1]};
    end
    sclk_in <= 1'b1;
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the serial channel over AHB-Lite.
// Assumes the divider resets to one, so a bit lasts 16 clock cycles.
`timescale 1ns/1ns
module tb_top;
  import serial_channel_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = '0;
  logic hwrite = 1'b0;
  logic clk_en = 1'b1;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic rxd, cts, sclk_in, hung;
  ahb_req_type req;
  pins_out_type pins;
  int fail_count = 0;
  int checked = 0;
  int txi = 0;
  int rxi = 0;
  int t0;
  logic [31:0] rd;
  logic [9:0] q;
  logic [7:0] b;
  assign req = '{hsel, htrans, haddr, hwrite, hsize, hreadyout};
  always #(CLK_PERIOD_NS / 2) hclk = ~hclk;
  serial_channel_tx_and_errors #(.DIV_WIDTH(8)) DUT (
    .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .ahb_req(req),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .receive_data_pin(rxd), .clear_to_send_pin(cts),
    .serial_shift_clock_in(sclk_in), .pins(pins));
  remote_peer peer (
    .hclk(hclk), .txd(pins.txd), .sclk_out(pins.sclk_out),
    .rxd(rxd), .cts(cts), .sclk_in(sclk_in), .hung(hung));
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    if (pins.tx_irq === 1'b1) txi++;
    if (pins.rx_irq === 1'b1) rxi++;
    if (hung === 1'b1) begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        end_sim();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    hsize <= 3'b010;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic t_reset();
    chk(pins.txd, 1'b1);
    // A write while the block is frozen must leave no trace.
    clk_en <= 1'b0;
    bus(1'b1, OFS_CTRL, 32'h0000_0055);
    clk_en <= 1'b1;
    bus(1'b0, OFS_CTRL, '0);
    chk(rd, {24'h00_0000, CTRL_RESET});
    bus(1'b0, 8'h10, '0);
    chk(rd, 32'h0000_0000);
    chk(hresp, 1'b0);
    bus(1'b0, OFS_STAT, '0);
    chk(rd[ST_TXE], 1'b1);
  endtask
  task automatic t_uart_tx();
    logic [7:0] c [4] = '{8'h02, 8'h05, 8'h0E, 8'h03};
    logic [7:0] d [4] = '{8'h25, 8'h31, 8'h07, 8'h5A};
    logic [9:0] e [4] = '{10'h125, 10'h1B1, 10'h207, 10'h25A};
    int nb [4] = '{8, 8, 9, 9};
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_CTRL, {24'h00_0000, c[i]});
      t0 = txi;
      bus(1'b1, OFS_DATA, {24'h00_0000, d[i]});
      peer.recv(nb[i], q);
      chk(q, e[i]);
      chk(txi - t0, 1);
      peer.tick(16);
    end
  endtask
  task automatic t_handshake();
    int n;
    bus(1'b1, OFS_CTRL, 32'h0000_0042);
    peer.hold(1'b1);
    bus(1'b1, OFS_DATA, 32'h0000_005A);
    n = 0;
    repeat (100) begin
      @(negedge hclk);
      if (pins.txd !== 1'b1) n++;
    end
    chk(n, 0);
    peer.hold(1'b0);
    peer.recv(8, q);
    chk(q, 10'h15A);
    peer.tick(16);
  endtask
  task automatic t_rx_errors();
    bus(1'b1, OFS_CTRL, 32'h0000_0006);
    t0 = rxi;
    peer.send(9, 9'h001, 1'b1);
    chk(rxi - t0, 1);
    bus(1'b0, OFS_STAT, '0);
    chk(rd[ST_PARITY_ERROR_FLAG], 1'b1);
    bus(1'b0, OFS_DATA, '0);
    chk(rd[7:0], 8'h01);
    bus(1'b1, OFS_CTRL, 32'h0000_0007);
    peer.send(9, 9'h103, 1'b1);
    bus(1'b0, OFS_STAT, '0);
    chk(rd[ST_PARITY_ERROR_FLAG], 1'b0);
    chk(rd[ST_RB8], 1'b1);
    bus(1'b0, OFS_DATA, '0);
    chk(rd[7:0], 8'h03);
    bus(1'b1, OFS_CTRL, 32'h0000_0002);
    peer.send(8, 9'h011, 1'b1);
    peer.send(8, 9'h022, 1'b1);
    bus(1'b0, OFS_STAT, '0);
    chk(rd[ST_OVERRUN_ERROR_FLAG], 1'b1);
    bus(1'b0, OFS_DATA, '0);
    chk(rd[7:0], 8'h11);
    peer.send(8, 9'h033, 1'b0);
    bus(1'b0, OFS_STAT, '0);
    chk(rd[ST_FRAMING_ERROR_FLAG], 1'b1);
    chk(rd[ST_OVERRUN_ERROR_FLAG], 1'b0);
  endtask
  task automatic t_shift();
    int f;
    bus(1'b1, OFS_CTRL, 32'h0000_0000);
    t0 = txi;
    bus(1'b1, OFS_DATA, 32'h0000_0096);
    chk(pins.sclk_oe_n, 1'b0);
    peer.shift_int(b, f);
    chk(b, 8'h96);
    chk(f, 8);
    chk(txi - t0, 1);
    for (int i = 0; i < 2; i++) begin
      bus(1'b1, OFS_CTRL, (i == 1) ? 32'h0000_0030 : 32'h0000_0010);
      t0 = txi;
      bus(1'b1, OFS_DATA, 32'h0000_00C3);
      peer.tick(40);
      chk(txi - t0, 0);
      peer.shift_ext(i == 1, b);
      peer.tick(8);
      chk(b, 8'hC3);
      chk(txi - t0, 1);
    end
  endtask
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_uart_tx();
    t_handshake();
    t_rx_errors();
    t_shift();
    end_sim();
  end
endmodule
